// >>> hw/dpt_top.sv
// Dead-time PWM sequencer with fault input actions and dither
// Notes on behaviour
// - Action 9: input rising edge during its on-time blanks that output until on-time ends.
// - Action 9: input A acts on output A only, input B on output B.
// - Actions 9 and 10 never alter the phase sequence or period.
// - Action 10: output held off while its input is high, any phase.
// - Action 10: input dropping mid on-time keeps output off until that on-time ends.
// - Action 10: input A gates output A only, input B output B.
// - Action 2: end on-time, run other compare, wait; release restarts own dead-time.
// - Dither fraction added to accumulator once per timer cycle.
// - Accumulator carry lengthens the chosen phase by one clock.
// - Placement selects on B, on A and B, dead B, or dead A and B.
// - No dither extension in dual-slope shape.
// - One-ramp: on-time placements add one clock, dead-time placements none.
// - Two-ramp and four-ramp additions follow the per-placement counts.
// - Where cycle must not grow, the following phase is shortened by one.
// - Each input has its own action select field.
// - Action 7 halts until restart command; stays halted if input still high.
//
// Our own choices: the strobed register port and the register offsets.
`default_nettype none
`include "dpt_params.svh"
module dpt_top
	import dpt_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire logic [`DPT_ADDR_W-1:0] reg_addr,
	input  wire logic [`DPT_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [`DPT_DATA_W-1:0] reg_rdata,
	input  wire logic                   event_a,
	input  wire logic                   event_b,
	output logic                        wave_out_a,
	output logic                        wave_out_b,
	output logic                        irq
);
	dpt_dither_if dith_bus ();
	dpt_dither u_dither (
		.mclk  (mclk),
		.rst_b (rst_b),
		.bus   (dith_bus)
	);
	// Register file state
	logic                   enable;
	logic                   next_enable;
	dpt_shape_type          shape;
	dpt_shape_type          next_shape;
	logic [`DPT_ACT_W-1:0]  act_a;
	logic [`DPT_ACT_W-1:0]  next_act_a;
	logic [`DPT_ACT_W-1:0]  act_b;
	logic [`DPT_ACT_W-1:0]  next_act_b;
	dpt_place_type          place;
	dpt_place_type          next_place;
	logic [`DPT_FRAC_W-1:0] frac;
	logic [`DPT_FRAC_W-1:0] next_frac;
	logic [`DPT_LEN_W-1:0]  len       [4];
	logic [`DPT_LEN_W-1:0]  next_len  [4];
	logic [`DPT_ST_W-1:0]   status;
	logic [`DPT_ST_W-1:0]   next_status;
	logic [`DPT_ST_W-1:0]   mask;
	logic [`DPT_ST_W-1:0]   next_mask;
	logic [`DPT_DATA_W-1:0] next_rdata;
	logic                   restart;
	logic                   next_restart;
	// Input synchronisers
	logic ev_a_m;
	logic ev_a_s;
	logic ev_a_p;
	logic ev_b_m;
	logic ev_b_s;
	logic ev_b_p;
	// Sequencer state
	dpt_phase_type          phase;
	dpt_phase_type          next_phase;
	logic [`DPT_LEN_W:0]    cnt;
	logic [`DPT_LEN_W:0]    next_cnt;
	logic                   pend;
	logic                   next_pend;
	logic                   pend_b;
	logic                   next_pend_b;
	logic                   sw_wait;
	logic                   next_sw_wait;
	logic                   blk_a;
	logic                   next_blk_a;
	logic                   blk_b;
	logic                   next_blk_b;
	logic                   next_wave_a;
	logic                   next_wave_b;
	logic                   next_irq;
	logic [1:0]             pidx;
	logic [`DPT_LEN_W+1:0]  eff_len;
	logic                   phase_end;
	logic                   rise_a;
	logic                   rise_b;
	logic                   hit_a;
	logic                   hit_b;
	logic                   stop_all;
	logic                   sw_fault;
	logic                   cycle_end;
	// Two flops before any logic sees the event lines
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ev_a_m <= 1'b0;
			ev_a_s <= 1'b0;
			ev_a_p <= 1'b0;
			ev_b_m <= 1'b0;
			ev_b_s <= 1'b0;
			ev_b_p <= 1'b0;
		end else begin
			ev_a_m <= event_a;
			ev_a_s <= ev_a_m;
			ev_a_p <= ev_a_s;
			ev_b_m <= event_b;
			ev_b_s <= ev_b_m;
			ev_b_p <= ev_b_s;
		end
	end

	assign rise_a = ev_a_s && !ev_a_p;
	assign rise_b = ev_b_s && !ev_b_p;
	// Only implemented actions count as faults
	assign hit_a = ev_a_s && (act_a == `DPT_ACT_EXEC_WAIT || act_a == `DPT_ACT_STOP_ALL ||
		act_a == `DPT_ACT_SW_WAIT || act_a == `DPT_ACT_EDGE_BLK || act_a == `DPT_ACT_LEVEL_BLK);
	assign hit_b = ev_b_s && (act_b == `DPT_ACT_EXEC_WAIT || act_b == `DPT_ACT_STOP_ALL ||
		act_b == `DPT_ACT_SW_WAIT || act_b == `DPT_ACT_EDGE_BLK || act_b == `DPT_ACT_LEVEL_BLK);
	assign stop_all = (ev_a_s && act_a == `DPT_ACT_STOP_ALL) || (ev_b_s && act_b == `DPT_ACT_STOP_ALL);
	assign sw_fault = (ev_a_s && act_a == `DPT_ACT_SW_WAIT) || (ev_b_s && act_b == `DPT_ACT_SW_WAIT);

	// Phase length with dither extension and compensation
	assign pidx = (phase == DPT_OTA) ? 2'd1 : (phase == DPT_DTB) ? 2'd2 : (phase == DPT_OTB) ? 2'd3 : 2'd0;
	always_comb begin
		eff_len = {2'b00, len[pidx]} + {{(`DPT_LEN_W+1){1'b0}}, dith_bus.ext[pidx]}
			- {{(`DPT_LEN_W+1){1'b0}}, dith_bus.comp[pidx]};
		if (eff_len[`DPT_LEN_W+1] || eff_len == '0)
			eff_len = {{(`DPT_LEN_W+1){1'b0}}, 1'b1};
	end
	assign phase_end = ({1'b0, cnt} + {{(`DPT_LEN_W+1){1'b0}}, 1'b1}) >= eff_len;
	assign cycle_end = enable && phase == DPT_OTB && phase_end;
	assign dith_bus.cycle_end = cycle_end;
	assign dith_bus.frac      = frac;
	assign dith_bus.place     = place;
	assign dith_bus.shape     = shape;
	// Phase sequencer; actions 9 and 10 never touch it
	always_comb begin
		next_phase   = phase;
		next_cnt     = cnt;
		next_pend    = pend;
		next_pend_b  = pend_b;
		next_sw_wait = sw_wait;
		if (!enable) begin
			next_phase   = DPT_DTA;
			next_cnt     = '0;
			next_pend    = 1'b0;
			next_sw_wait = 1'b0;
		end else if (sw_fault && !sw_wait) begin
			next_phase   = DPT_WAIT;
			next_sw_wait = 1'b1;
			next_pend    = 1'b0;
			next_cnt     = '0;
		end else if (phase == DPT_WAIT) begin
			if (sw_wait) begin
				if (restart && !sw_fault) begin
					next_phase   = DPT_DTA;
					next_sw_wait = 1'b0;
				end
			end else if (!(pend_b ? ev_b_s : ev_a_s)) begin
				next_phase = pend_b ? DPT_DTB : DPT_DTA;
				next_pend  = 1'b0;
			end
		end else if (!pend && ev_a_s && act_a == `DPT_ACT_EXEC_WAIT && (phase == DPT_DTA || phase == DPT_OTA)) begin
			next_phase  = DPT_DTB;
			next_pend   = 1'b1;
			next_pend_b = 1'b0;
			next_cnt    = '0;
		end else if (!pend && ev_b_s && act_b == `DPT_ACT_EXEC_WAIT && (phase == DPT_DTB || phase == DPT_OTB)) begin
			next_phase  = DPT_DTA;
			next_pend   = 1'b1;
			next_pend_b = 1'b1;
			next_cnt    = '0;
		end else if (phase_end) begin
			next_cnt = '0;
			case (phase)
				DPT_DTA: next_phase = DPT_OTA;
				DPT_OTA: next_phase = (pend && pend_b) ? (ev_b_s ? DPT_WAIT : DPT_DTB) : DPT_DTB;
				DPT_DTB: next_phase = DPT_OTB;
				DPT_OTB: next_phase = (pend && !pend_b) ? (ev_a_s ? DPT_WAIT : DPT_DTA) : DPT_DTA;
				default: next_phase = DPT_DTA;
			endcase
			if ((phase == DPT_OTA && pend && pend_b && !ev_b_s) || (phase == DPT_OTB && pend && !pend_b && !ev_a_s))
				next_pend = 1'b0;
		end else begin
			next_cnt = cnt + {{`DPT_LEN_W{1'b0}}, 1'b1};
		end
	end

	// Output blanking; an edge in the last on-time cycle sets nothing
	always_comb begin
		next_blk_a = blk_a;
		next_blk_b = blk_b;
		if (phase != DPT_OTA || (phase_end && !(act_a == `DPT_ACT_LEVEL_BLK && ev_a_s)))
			next_blk_a = 1'b0;
		if (phase != DPT_OTB || (phase_end && !(act_b == `DPT_ACT_LEVEL_BLK && ev_b_s)))
			next_blk_b = 1'b0;
		if (phase == DPT_OTA && !phase_end && act_a == `DPT_ACT_EDGE_BLK && rise_a)
			next_blk_a = 1'b1;
		if (phase == DPT_OTB && !phase_end && act_b == `DPT_ACT_EDGE_BLK && rise_b)
			next_blk_b = 1'b1;
		if (act_a == `DPT_ACT_LEVEL_BLK && ev_a_s && next_phase == DPT_OTA)
			next_blk_a = 1'b1;
		if (act_b == `DPT_ACT_LEVEL_BLK && ev_b_s && next_phase == DPT_OTB)
			next_blk_b = 1'b1;
		next_wave_a = enable && next_phase == DPT_OTA && !next_blk_a && !stop_all
			&& !(act_a == `DPT_ACT_LEVEL_BLK && ev_a_s);
		next_wave_b = enable && next_phase == DPT_OTB && !next_blk_b && !stop_all
			&& !(act_b == `DPT_ACT_LEVEL_BLK && ev_b_s);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			phase      <= DPT_DTA;
			cnt        <= '0;
			pend       <= 1'b0;
			pend_b     <= 1'b0;
			sw_wait    <= 1'b0;
			blk_a      <= 1'b0;
			blk_b      <= 1'b0;
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end else begin
			phase      <= next_phase;
			cnt        <= next_cnt;
			pend       <= next_pend;
			pend_b     <= next_pend_b;
			sw_wait    <= next_sw_wait;
			blk_a      <= next_blk_a;
			blk_b      <= next_blk_b;
			wave_out_a <= next_wave_a;
			wave_out_b <= next_wave_b;
		end
	end

	// Register bus; status sets win over a same-cycle clear
	always_comb begin
		next_enable  = enable;
		next_shape   = shape;
		next_act_a   = act_a;
		next_act_b   = act_b;
		next_place   = place;
		next_frac    = frac;
		next_mask    = mask;
		next_restart = 1'b0;
		next_status  = status;
		for (int i = 0; i < 4; i++) begin
			next_len[i] = len[i];
		end
		if (reg_write) begin
			case (reg_addr)
				`DPT_OFS_CTRL: begin
					next_enable  = reg_wdata[`DPT_CTRL_EN];
					next_shape   = dpt_shape_type'(reg_wdata[`DPT_CTRL_SHAPE_LO +: 2]);
					next_restart = reg_wdata[`DPT_CTRL_RESTART];
				end
				`DPT_OFS_INPUT_A: next_act_a = reg_wdata[`DPT_ACT_W-1:0];
				`DPT_OFS_INPUT_B: next_act_b = reg_wdata[`DPT_ACT_W-1:0];
				`DPT_OFS_DITHER:  next_place = dpt_place_type'(reg_wdata[1:0]);
				`DPT_OFS_FRAC:    next_frac  = reg_wdata[`DPT_FRAC_W-1:0];
				`DPT_OFS_STATUS:  next_status = status & ~reg_wdata[`DPT_ST_W-1:0];
				`DPT_OFS_MASK:    next_mask  = reg_wdata[`DPT_ST_W-1:0];
				default: begin
					if (reg_addr >= `DPT_OFS_LEN_BASE && reg_addr < `DPT_OFS_STATUS)
						next_len[2'(reg_addr - `DPT_OFS_LEN_BASE)] = reg_wdata[`DPT_LEN_W-1:0];
				end
			endcase
		end
		if (cycle_end)
			next_status[`DPT_ST_CYCLE] = 1'b1;
		if (cycle_end && dith_bus.active)
			next_status[`DPT_ST_DITHER] = 1'b1;
		if (rise_a && hit_a)
			next_status[`DPT_ST_FAULT_A] = 1'b1;
		if (rise_b && hit_b)
			next_status[`DPT_ST_FAULT_B] = 1'b1;
		next_irq = |(next_status & next_mask);
		next_rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				`DPT_OFS_CTRL:    next_rdata = {{(`DPT_DATA_W-3){1'b0}}, shape, enable};
				`DPT_OFS_INPUT_A: next_rdata = {{(`DPT_DATA_W-`DPT_ACT_W){1'b0}}, act_a};
				`DPT_OFS_INPUT_B: next_rdata = {{(`DPT_DATA_W-`DPT_ACT_W){1'b0}}, act_b};
				`DPT_OFS_DITHER:  next_rdata = {{(`DPT_DATA_W-2){1'b0}}, place};
				`DPT_OFS_FRAC:    next_rdata = {{(`DPT_DATA_W-`DPT_FRAC_W){1'b0}}, frac};
				`DPT_OFS_STATUS:  next_rdata = {{(`DPT_DATA_W-`DPT_ST_W){1'b0}}, status};
				`DPT_OFS_MASK:    next_rdata = {{(`DPT_DATA_W-`DPT_ST_W){1'b0}}, mask};
				`DPT_OFS_STATE:   next_rdata = {{(`DPT_DATA_W-8){1'b0}}, blk_b, blk_a, wave_out_b, wave_out_a,
					sw_wait, phase};
				default: begin
					if (reg_addr >= `DPT_OFS_LEN_BASE && reg_addr < `DPT_OFS_STATUS)
						next_rdata = {{(`DPT_DATA_W-`DPT_LEN_W){1'b0}}, len[2'(reg_addr - `DPT_OFS_LEN_BASE)]};
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			enable    <= 1'b0;
			shape     <= DPT_ONE_RAMP;
			act_a     <= `DPT_ACT_NONE;
			act_b     <= `DPT_ACT_NONE;
			place     <= DPT_PL_OTB;
			frac      <= '0;
			status    <= '0;
			mask      <= `DPT_MASK_RESET;
			restart   <= 1'b0;
			reg_rdata <= '0;
			irq       <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				len[i] <= `DPT_LEN_RESET;
			end
		end else begin
			enable    <= next_enable;
			shape     <= next_shape;
			act_a     <= next_act_a;
			act_b     <= next_act_b;
			place     <= next_place;
			frac      <= next_frac;
			status    <= next_status;
			mask      <= next_mask;
			restart   <= next_restart;
			reg_rdata <= next_rdata;
			irq       <= next_irq;
			for (int i = 0; i < 4; i++) begin
				len[i] <= next_len[i];
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/dpt_params.svh
// Constants for the dead-time PWM timer fault input and dither block
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH

`define DPT_ADDR_W        4
`define DPT_DATA_W        16
`define DPT_LEN_W         12
`define DPT_FRAC_W        4
`define DPT_ACT_W         4

`define DPT_OFS_CTRL      4'h0
`define DPT_OFS_INPUT_A   4'h1
`define DPT_OFS_INPUT_B   4'h2
`define DPT_OFS_DITHER    4'h3
`define DPT_OFS_FRAC      4'h4
`define DPT_OFS_LEN_BASE  4'h5
`define DPT_OFS_STATUS    4'h9
`define DPT_OFS_MASK      4'ha
`define DPT_OFS_STATE     4'hb

`define DPT_CTRL_EN       0
`define DPT_CTRL_SHAPE_LO 1
`define DPT_CTRL_RESTART  3

`define DPT_ACT_NONE      4'h0
`define DPT_ACT_EXEC_WAIT 4'h2
`define DPT_ACT_STOP_ALL  4'h4
`define DPT_ACT_SW_WAIT   4'h7
`define DPT_ACT_EDGE_BLK  4'h9
`define DPT_ACT_LEVEL_BLK 4'ha

`define DPT_ST_CYCLE      0
`define DPT_ST_DITHER     1
`define DPT_ST_FAULT_A    2
`define DPT_ST_FAULT_B    3
`define DPT_ST_W          4

`define DPT_LEN_RESET     12'h00f
`define DPT_MASK_RESET    4'h0

`endif

// >>> hw/dpt_pkg.sv
// Types for the dead-time PWM timer fault input and dither block
`default_nettype none
package dpt_pkg;
	typedef enum logic [1:0] {
		DPT_ONE_RAMP  = 2'h0,
		DPT_TWO_RAMP  = 2'h1,
		DPT_FOUR_RAMP = 2'h2,
		DPT_DUAL      = 2'h3
	} dpt_shape_type;

	typedef enum logic [1:0] {
		DPT_PL_OTB   = 2'h0,
		DPT_PL_OTAB  = 2'h1,
		DPT_PL_DTB   = 2'h2,
		DPT_PL_DTAB  = 2'h3
	} dpt_place_type;

	// Gray codes along dead A, on A, dead B, on B
	typedef enum logic [2:0] {
		DPT_DTA  = 3'h0,
		DPT_OTA  = 3'h1,
		DPT_DTB  = 3'h3,
		DPT_OTB  = 3'h2,
		DPT_WAIT = 3'h6
	} dpt_phase_type;
endpackage
`default_nettype wire

// >>> hw/dpt_dither_if.sv
// Carrier between sequencer and dither unit
`default_nettype none
`include "dpt_params.svh"
interface dpt_dither_if;
	import dpt_pkg::*;
	logic                   cycle_end;
	logic [`DPT_FRAC_W-1:0] frac;
	dpt_place_type          place;
	dpt_shape_type          shape;
	logic                   active;
	logic [3:0]             ext;
	logic [3:0]             comp;

	modport dith (input cycle_end, input frac, input place, input shape,
		output active, output ext, output comp);
	modport seq (output cycle_end, output frac, output place, output shape,
		input active, input ext, input comp);
endinterface
`default_nettype wire

// >>> hw/dpt_dither.sv
// Dither accumulator and per-phase extend/shorten masks
`default_nettype none
`include "dpt_params.svh"
module dpt_dither
	import dpt_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_b,
	dpt_dither_if.dith bus
);
	logic [`DPT_FRAC_W-1:0] acc;
	logic [`DPT_FRAC_W-1:0] next_acc;
	logic                   ovf;
	logic                   next_ovf;
	logic [`DPT_FRAC_W:0]   sum;
	logic [3:0]             place_mask;

	always_comb begin
		sum = {1'b0, acc} + {1'b0, bus.frac};
		next_acc = acc;
		next_ovf = ovf;
		if (bus.cycle_end) begin
			next_acc = sum[`DPT_FRAC_W-1:0];
			next_ovf = sum[`DPT_FRAC_W];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc <= '0;
			ovf <= 1'b0;
		end else begin
			acc <= next_acc;
			ovf <= next_ovf;
		end
	end

	// Phase index: 0 dead A, 1 on A, 2 dead B, 3 on B
	always_comb begin
		case (bus.place)
			DPT_PL_OTB:  place_mask = 4'h8;
			DPT_PL_OTAB: place_mask = 4'ha;
			DPT_PL_DTB:  place_mask = 4'h4;
			DPT_PL_DTAB: place_mask = 4'h5;
			default:     place_mask = 4'h0;
		endcase
	end

	assign bus.active = ovf && (bus.shape != DPT_DUAL);

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_phase
			logic need_comp;
			// Phases that do not set the cycle length are paid back by the next state
			always_comb begin
				case (bus.shape)
					DPT_ONE_RAMP: need_comp = (i % 2 == 0) || (i == 1);
					DPT_TWO_RAMP: need_comp = (i % 2 == 0);
					default:      need_comp = 1'b0;
				endcase
			end
			assign bus.ext[i] = bus.active && place_mask[i];
			assign bus.comp[(i + 1) % 4] = bus.ext[i] && need_comp;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> testbench/dpt_event_net.sv
// Event network model feeding the two fault inputs of the timer
`default_nettype none
module dpt_event_net (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic req_a,
	input  wire logic req_b,
	output logic      event_a,
	output logic      event_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// One channel hop; the timer resynchronises, so the phase is free
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			event_a <= 1'b0;
			event_b <= 1'b0;
		end else begin
			event_a <= req_a;
			event_b <= req_b;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/dpt_top_props.sv
// Concurrent checks on the ports of the fault input and dither block
`default_nettype none
`include "dpt_params.svh"
module dpt_top_props (
	input wire logic                   mclk,
	input wire logic                   rst_b,
	input wire logic [`DPT_ADDR_W-1:0] reg_addr,
	input wire logic [`DPT_DATA_W-1:0] reg_wdata,
	input wire logic                   reg_write,
	input wire logic                   reg_read,
	input wire logic [`DPT_DATA_W-1:0] reg_rdata,
	input wire logic                   event_a,
	input wire logic                   event_b,
	input wire logic                   wave_out_a,
	input wire logic                   wave_out_b,
	input wire logic                   irq
);
	logic [3:0] act_a;
	logic [3:0] act_b;
	logic [3:0] mask_s;
	logic       en;
	logic [4:0] ea_h;
	logic [4:0] eb_h;
	// Shadows of the few fields the checks depend on
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			act_a  <= 4'h0;
			act_b  <= 4'h0;
			mask_s <= 4'h0;
			en     <= 1'b0;
			ea_h   <= 5'h00;
			eb_h   <= 5'h00;
		end else begin
			ea_h <= {ea_h[3:0], event_a};
			eb_h <= {eb_h[3:0], event_b};
			if (reg_write && reg_addr == `DPT_OFS_INPUT_A) act_a <= reg_wdata[3:0];
			if (reg_write && reg_addr == `DPT_OFS_INPUT_B) act_b <= reg_wdata[3:0];
			if (reg_write && reg_addr == `DPT_OFS_MASK) mask_s <= reg_wdata[3:0];
			if (reg_write && reg_addr == `DPT_OFS_CTRL) en <= reg_wdata[`DPT_CTRL_EN];
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside read cycle");
	AST_UNMAPPED: assert property (reg_read && reg_addr > `DPT_OFS_STATE |=> reg_rdata == 16'h0000)
		else $error("unmapped read returned data");
	AST_IRQ_MASKED: assert property (mask_s == 4'h0 && $past(mask_s) == 4'h0 |-> !irq)
		else $error("interrupt high with all sources masked");
	AST_DISABLED_QUIET: assert property (!en && !$past(en) |-> !wave_out_a && !wave_out_b)
		else $error("output active while timer disabled");
	AST_LEVEL_A: assert property (act_a == `DPT_ACT_LEVEL_BLK && event_a && ea_h[2:0] == 3'h7 |-> !wave_out_a)
		else $error("output a active while level input held");
	AST_EDGE_A: assert property (act_a == `DPT_ACT_EDGE_BLK && ea_h[3:2] == 2'b01 && $past(wave_out_a)
		|-> !wave_out_a ##1 !wave_out_a)
		else $error("output a not blanked after input edge");
	AST_EXEC_WAIT_A: assert property (act_a == `DPT_ACT_EXEC_WAIT && event_a && ea_h[2:0] == 3'h7
		|-> !wave_out_a)
		else $error("output a active during held fault");
	AST_SW_WAIT_B: assert property (act_b == `DPT_ACT_SW_WAIT && event_b && eb_h[2:0] == 3'h7
		|-> !wave_out_a && !wave_out_b)
		else $error("outputs active while halted for restart");
	COV_EDGE: cover property (act_a == `DPT_ACT_EDGE_BLK && ea_h[3:2] == 2'b01 && $past(wave_out_a));
	COV_IRQ: cover property ($rose(irq));
	COV_HALT: cover property (act_b == `DPT_ACT_SW_WAIT && eb_h[2:0] == 3'h7);
endmodule
bind dpt_top dpt_top_props dpt_top_props_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.event_a(event_a), .event_b(event_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq(irq));
`default_nettype wire

// >>> testbench/test_dpt_top.sv
// Directed bench for the fault input and dither block
`default_nettype none
`include "dpt_params.svh"
module test_dpt_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic [`DPT_ADDR_W-1:0] reg_addr  = 4'h0;
	logic [`DPT_DATA_W-1:0] reg_wdata = 16'h0000;
	logic [`DPT_DATA_W-1:0] reg_rdata;
	logic                   mclk      = 1'b0;
	logic                   rst_b     = 1'b0;
	logic                   reg_write = 1'b0;
	logic                   reg_read  = 1'b0;
	logic                   req_a     = 1'b0;
	logic                   req_b     = 1'b0;
	logic                   event_a;
	logic                   event_b;
	logic                   wave_out_a;
	logic                   wave_out_b;
	logic                   irq;
	int                     n_errors  = 0;
	int                     n_tests   = 0;
	// Extra clocks per cycle, shape major, placement minor
	int                     add_tab [16] = '{1, 1, 0, 0, 1, 2, 0, 0, 1, 2, 1, 2, 0, 0, 0, 0};
	logic [3:0]             codes [8] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h8, 4'hb, 4'hf};
	always #2 mclk = ~mclk;
	dpt_event_net dpt_event_net_i (.mclk(mclk), .rst_b(rst_b), .req_a(req_a), .req_b(req_b),
		.event_a(event_a), .event_b(event_b));
	dpt_top dpt_top_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .event_a(event_a),
		.event_b(event_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq(irq));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic ev(input logic a, input logic b);
		@(posedge mclk);
		req_a <= a;
		req_b <= b;
	endtask
	// Cycles spanned by n periods of output a, from one rise on
	task automatic per(input int n, output int p);
		int   r;
		logic q;
		p = 0;
		r = -1;
		q = 1'b1;
		for (int i = 0; i < 400 && r < n; i++) begin
			@(negedge mclk);
			if (r >= 0) p++;
			if (wave_out_a === 1'b1 && q === 1'b0) r++;
			q = wave_out_a;
		end
	endtask
	task automatic hi(input int n, output int ha, output int hb);
		ha = 0;
		hb = 0;
		repeat (n) begin
			@(negedge mclk);
			ha += int'(wave_out_a === 1'b1);
			hb += int'(wave_out_b === 1'b1);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#80000;
		n_errors++;
		final_report();
	end
	initial begin
		logic [15:0] d;
		int          p;
		int          ha;
		int          hb;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		rd(`DPT_OFS_LEN_BASE, d);
		check(d, {4'h0, `DPT_LEN_RESET});
		rd(`DPT_OFS_MASK, d);
		check(d, 16'h0000);
		rd(4'hc, d);
		check(d, 16'h0000);
		wr(`DPT_OFS_LEN_BASE, 16'h0003);
		wr(4'h6, 16'h000c);
		wr(4'h7, 16'h0003);
		wr(4'h8, 16'h0008);
		rd(4'h6, d);
		check(d, 16'h000c);
		wr(`DPT_OFS_CTRL, 16'h0003);
		per(1, p);
		check(16'(p), 16'd26);
		// Edge blanking on A, input then held high
		wr(`DPT_OFS_INPUT_A, 16'h0009);
		per(1, p);
		ev(1'b1, 1'b0);
		hi(14, ha, hb);
		check(16'(ha < 8), 16'h0001);
		per(1, p);
		check(16'(p), 16'd26);
		hi(52, ha, hb);
		check(16'(ha), 16'd24);
		check(16'(hb), 16'd16);
		// Level blanking on A
		ev(1'b0, 1'b0);
		wr(`DPT_OFS_INPUT_A, 16'h000a);
		ev(1'b1, 1'b0);
		hi(4, ha, hb);
		hi(52, ha, hb);
		check(16'(ha), 16'd0);
		check(16'(hb), 16'd16);
		d = 16'h0000;
		for (int i = 0; i < 40 && d[2:0] !== 3'h1; i++) rd(`DPT_OFS_STATE, d);
		ev(1'b0, 1'b0);
		hi(12, ha, hb);
		check({13'h0000, d[2:0]}, 16'h0001);
		check(16'(ha), 16'd0);
		per(1, p);
		check(16'(p), 16'd26);
		// No-action and unimplemented codes on A, B left at zero
		wr(`DPT_OFS_INPUT_A, 16'h0000);
		ev(1'b1, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(`DPT_OFS_INPUT_A, {12'h000, codes[i]});
			hi(4, ha, hb);
			hi(52, ha, hb);
			check(16'(ha), 16'd24);
			check(16'(hb), 16'd16);
		end
		// Stop-all action on A silences both outputs while held
		wr(`DPT_OFS_INPUT_A, 16'h0004);
		hi(4, ha, hb);
		hi(52, ha, hb);
		check(16'(ha + hb), 16'd0);
		// Execute other compare and wait
		ev(1'b0, 1'b0);
		wr(`DPT_OFS_INPUT_A, 16'h0002);
		wr(`DPT_OFS_STATUS, 16'h000f);
		ev(1'b1, 1'b0);
		hi(4, ha, hb);
		hi(56, ha, hb);
		check(16'(ha), 16'd0);
		rd(`DPT_OFS_STATE, d);
		check({13'h0000, d[2:0]}, 16'h0006);
		rd(`DPT_OFS_STATUS, d);
		check(d & 16'h0004, 16'h0004);
		ev(1'b0, 1'b0);
		per(1, p);
		check(16'(p), 16'd26);
		// Same action on B: runs compare A, waits, resumes at dead time B
		wr(`DPT_OFS_INPUT_A, 16'h0000);
		wr(`DPT_OFS_INPUT_B, 16'h0002);
		ev(1'b0, 1'b1);
		hi(4, ha, hb);
		hi(56, ha, hb);
		check(16'(hb), 16'd0);
		rd(`DPT_OFS_STATE, d);
		check({13'h0000, d[2:0]}, 16'h0006);
		ev(1'b0, 1'b0);
		per(1, p);
		check(16'(p), 16'd26);
		// Halt for software restart on B
		wr(`DPT_OFS_INPUT_A, 16'h0000);
		wr(`DPT_OFS_INPUT_B, 16'h0007);
		ev(1'b0, 1'b1);
		hi(10, ha, hb);
		rd(`DPT_OFS_STATE, d);
		check(d & 16'h0008, 16'h0008);
		wr(`DPT_OFS_CTRL, 16'h000b);
		hi(10, ha, hb);
		check(16'(ha + hb), 16'd0);
		rd(`DPT_OFS_STATE, d);
		check(d & 16'h0008, 16'h0008);
		ev(1'b0, 1'b0);
		hi(6, ha, hb);
		wr(`DPT_OFS_CTRL, 16'h000b);
		per(1, p);
		check(16'(p), 16'd26);
		wr(`DPT_OFS_INPUT_B, 16'h0000);
		// Half-clock fraction: one carry in every two cycles
		wr(`DPT_OFS_FRAC, 16'h0008);
		for (int s = 0; s < 16; s++) begin
			wr(`DPT_OFS_CTRL, 16'(((s >> 2) << 1) | 1));
			wr(`DPT_OFS_DITHER, 16'(s & 3));
			per(1, p);
			per(2, p);
			check(16'(p), 16'(52 + add_tab[s]));
			if (add_tab[s] == 0) begin
				hi(52, ha, hb);
				check(16'(hb), 16'(16 - int'(s < 8 && (s & 3) >= 2)));
			end
		end
		rd(`DPT_OFS_STATUS, d);
		check(d & 16'h0002, 16'h0002);
		// Cycle-end interrupt: raise, mask, clear
		wr(`DPT_OFS_FRAC, 16'h0000);
		wr(`DPT_OFS_STATUS, 16'h000f);
		wr(`DPT_OFS_MASK, 16'h0001);
		per(1, p);
		check({15'h0000, irq}, 16'h0001);
		wr(`DPT_OFS_MASK, 16'h0000);
		hi(2, ha, hb);
		check({15'h0000, irq}, 16'h0000);
		wr(`DPT_OFS_MASK, 16'h0001);
		hi(2, ha, hb);
		check({15'h0000, irq}, 16'h0001);
		wr(`DPT_OFS_STATUS, 16'h0001);
		hi(2, ha, hb);
		check({15'h0000, irq}, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
